/* verilog/asr_consts.svh */
// Constants for the status and main control register bank.
// Assumes an 8-bit register address and 8-bit register data.
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// Register offsets
`define ASR_OFF_ACCEL_FIRST 8'h06
`define ASR_OFF_ACCEL_LAST 8'h0b
`define ASR_OFF_Z_HIGH 8'h0b
`define ASR_OFF_SELFTEST_REPLY 8'h0c
`define ASR_OFF_SUPPLIER 8'h0f
`define ASR_OFF_ORI_NOW 8'h10
`define ASR_OFF_ORI_PRIOR 8'h11
`define ASR_OFF_TAP_DIR 8'h15
`define ASR_OFF_EVT_SRC 8'h16
`define ASR_OFF_STATUS 8'h18
`define ASR_OFF_RELEASE 8'h1a
`define ASR_OFF_MAIN_CTL 8'h1b

// Reset and fixed values
`define ASR_ST_IDLE 8'h55
`define ASR_ST_ACTIVE 8'haa
`define ASR_ORI_RESET 6'h20
`define ASR_MAIN_RESET 8'h00
`define ASR_SUPPLIER_ID 8'h3c

// Tap kind codes
`define ASR_TAP_NONE 2'h0
`define ASR_TAP_SINGLE 2'h1
`define ASR_TAP_DOUBLE 2'h2

// Bit positions of main_control
`define ASR_MC_MODE 7
`define ASR_MC_PREC 6
`define ASR_MC_NSIRQ 5
`define ASR_MC_RANGE_HI 4
`define ASR_MC_RANGE_LO 3
`define ASR_MC_TAP_EN 2
`define ASR_MC_MOTION_EN 1
`define ASR_MC_ORI_EN 0

// Bit position of any_event_flag in the status register
`define ASR_STATUS_ANY 4

`endif

/* verilog/asr_pkg.sv */
// Types for the status and main control register bank.
// Assumes asr_consts.svh supplies the numeric constants.
package asr_pkg;

    // Events from the sensing and detection core
    typedef struct packed {
        logic new_sample;
        logic tap_event;
        logic tap_double;
        logic [5:0] tap_dir;
        logic motion_level;
        logic ori_update;
        logic [5:0] ori_state;
    } asr_evt_t;

    // Decoded main_control fields
    typedef struct packed {
        logic operating_mode_select;
        logic precision_select;
        logic new_sample_irq_enable;
        logic [1:0] range_select;
        logic tap_detect_enable;
        logic motion_detect_enable;
        logic orientation_enable;
    } asr_ctrl_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] main_ctl;
        logic [7:0] selftest_reply;
        logic st_start_prev;
        logic st_clr;
        logic [5:0] ori_now;
        logic [5:0] ori_prior;
        logic ori_pend;
        logic [5:0] ori_pend_val;
        logic [5:0] tap_dir;
        logic new_sample;
        logic [1:0] tap_kind;
        logic motion;
        logic ori_chg;
        logic any_evt;
        logic irq;
        logic [7:0] rdata;
    } asr_state_t;

endpackage

/* verilog/asr_regs.sv */
// Status, identification and main control registers of a motion sensor.
// Assumes a serial front end that delivers one-cycle read and write strobes
// with an 8-bit address, and a detection core that delivers event pulses.
`timescale 1ns/100ps
`include "asr_consts.svh"

module asr_regs
    import asr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic rd_busy,
    input wire logic [11:0] z_accel,
    input wire asr_evt_t evt,
    input wire logic motion_unlatched,
    input wire logic selftest_start,
    output logic [7:0] reg_rdata,
    output logic selftest_start_clr,
    output asr_ctrl_t ctrl,
    output logic irq_out
);

    asr_state_t s_q;
    asr_state_t s_d;

    // Decoded access strobes
    logic wr_main;
    logic rd_st;
    logic rd_rel;
    logic rd_accel;
    logic st_rise;
    logic mode_on;
    logic tap_ev;
    logic motion_ev;
    logic ori_take;
    logic ori_changed;
    logic ns_ev;

    assign wr_main = reg_wr && (reg_addr == `ASR_OFF_MAIN_CTL);
    assign rd_st = reg_rd && (reg_addr == `ASR_OFF_SELFTEST_REPLY);
    assign rd_rel = reg_rd && (reg_addr == `ASR_OFF_RELEASE);
    assign rd_accel = reg_rd && (reg_addr >= `ASR_OFF_ACCEL_FIRST) && (reg_addr <= `ASR_OFF_ACCEL_LAST);
    assign st_rise = selftest_start && !s_q.st_start_prev;
    assign mode_on = s_q.main_ctl[`ASR_MC_MODE];

    // Events count only while operating; tap and motion also need their enable
    assign tap_ev = mode_on && s_q.main_ctl[`ASR_MC_TAP_EN] && evt.tap_event;
    assign motion_ev = mode_on && s_q.main_ctl[`ASR_MC_MOTION_EN] && evt.motion_level;
    assign ns_ev = mode_on && evt.new_sample;

    // Orientation takes a new state only when no read is in flight
    assign ori_take = s_q.ori_pend && !rd_busy && !reg_rd;
    assign ori_changed = ori_take && (s_q.ori_pend_val != s_q.ori_now) && mode_on
                         && s_q.main_ctl[`ASR_MC_ORI_EN];

    // Next-state logic for the whole bank
    always_comb begin
        s_d = s_q;
        s_d.st_clr = 1'b0;
        s_d.st_start_prev = selftest_start;

        // Main control; settings order is up to the host
        if (wr_main) begin
            s_d.main_ctl = reg_wdata;
        end

        // Communication self-test reply
        if (rd_st) begin
            s_d.selftest_reply = `ASR_ST_IDLE;
            s_d.st_clr = (s_q.selftest_reply == `ASR_ST_ACTIVE);
        end else if (st_rise) begin
            s_d.selftest_reply = `ASR_ST_ACTIVE;
        end

        // Capture incoming orientation, apply when no read is active
        if (evt.ori_update) begin
            s_d.ori_pend = 1'b1;
            s_d.ori_pend_val = evt.ori_state;
        end
        if (ori_take) begin
            s_d.ori_prior = s_q.ori_now;
            s_d.ori_now = s_q.ori_pend_val;
            s_d.ori_pend = evt.ori_update;
        end

        // Release clears all latched sources; new events below win
        if (rd_rel) begin
            s_d.tap_dir = 6'h00;
            s_d.tap_kind = `ASR_TAP_NONE;
            s_d.motion = 1'b0;
            s_d.ori_chg = 1'b0;
            s_d.new_sample = 1'b0;
            s_d.any_evt = 1'b0;
            s_d.irq = 1'b0;
        end
        if (rd_accel) begin
            s_d.new_sample = 1'b0;
        end

        // Latch events; a set in the clearing cycle is kept
        if (ns_ev) begin
            s_d.new_sample = 1'b1;
        end
        if (tap_ev) begin
            s_d.tap_dir = evt.tap_dir;
            s_d.tap_kind = evt.tap_double ? `ASR_TAP_DOUBLE : `ASR_TAP_SINGLE;
        end
        if (motion_unlatched) begin
            s_d.motion = motion_ev;
        end else if (motion_ev) begin
            s_d.motion = 1'b1;
        end
        if (ori_changed) begin
            s_d.ori_chg = 1'b1;
        end

        // Combined flag and interrupt latch; unlatched motion never latches
        if (tap_ev || (motion_ev && !motion_unlatched) || ori_changed || (ns_ev && s_q.main_ctl[`ASR_MC_NSIRQ])) begin
            s_d.any_evt = 1'b1;
        end
        s_d.irq = s_d.any_evt || (motion_unlatched && s_d.motion);

        // Read data mux, captured on the read strobe
        if (reg_rd) begin
            case (reg_addr)
                `ASR_OFF_Z_HIGH: s_d.rdata = z_accel[11:4];
                `ASR_OFF_SELFTEST_REPLY: s_d.rdata = s_q.selftest_reply;
                `ASR_OFF_SUPPLIER: s_d.rdata = `ASR_SUPPLIER_ID;
                `ASR_OFF_ORI_NOW: s_d.rdata = {2'h0, s_q.ori_now};
                `ASR_OFF_ORI_PRIOR: s_d.rdata = {2'h0, s_q.ori_prior};
                `ASR_OFF_TAP_DIR: s_d.rdata = {2'h0, s_q.tap_dir};
                `ASR_OFF_EVT_SRC: s_d.rdata = {3'h0, s_q.new_sample, s_q.tap_kind, s_q.motion, s_q.ori_chg};
                `ASR_OFF_STATUS: s_d.rdata = {3'h0, s_q.any_evt, 4'h0};
                `ASR_OFF_MAIN_CTL: s_d.rdata = s_q.main_ctl;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // State register; every field has a constant reset value
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q.main_ctl <= `ASR_MAIN_RESET;
            s_q.selftest_reply <= `ASR_ST_IDLE;
            s_q.st_start_prev <= 1'b0;
            s_q.st_clr <= 1'b0;
            s_q.ori_now <= `ASR_ORI_RESET;
            s_q.ori_prior <= `ASR_ORI_RESET;
            s_q.ori_pend <= 1'b0;
            s_q.ori_pend_val <= `ASR_ORI_RESET;
            s_q.tap_dir <= 6'h00;
            s_q.new_sample <= 1'b0;
            s_q.tap_kind <= `ASR_TAP_NONE;
            s_q.motion <= 1'b0;
            s_q.ori_chg <= 1'b0;
            s_q.any_evt <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state flops
    assign reg_rdata = s_q.rdata;
    assign selftest_start_clr = s_q.st_clr;
    assign irq_out = s_q.irq;
    assign ctrl.operating_mode_select = s_q.main_ctl[`ASR_MC_MODE];
    assign ctrl.precision_select = s_q.main_ctl[`ASR_MC_PREC];
    assign ctrl.new_sample_irq_enable = s_q.main_ctl[`ASR_MC_NSIRQ];
    assign ctrl.range_select = s_q.main_ctl[`ASR_MC_RANGE_HI:`ASR_MC_RANGE_LO];
    assign ctrl.tap_detect_enable = s_q.main_ctl[`ASR_MC_TAP_EN];
    assign ctrl.motion_detect_enable = s_q.main_ctl[`ASR_MC_MOTION_EN];
    assign ctrl.orientation_enable = s_q.main_ctl[`ASR_MC_ORI_EN];

    // Checks on the bank, all on the one clock
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    z_high_read_a: assert property ((reg_rd && reg_addr == `ASR_OFF_Z_HIGH) |=> reg_rdata == $past(z_accel[11:4]))
        else $error("z high byte read wrong");
    st_start_a: assert property ((selftest_start && !s_q.st_start_prev && !rd_st) |=> s_q.selftest_reply == 8'haa)
        else $error("self-test reply not set");
    st_restore_a: assert property (rd_st |=> s_q.selftest_reply == 8'h55)
        else $error("self-test reply not restored");
    st_clear_pulse_a: assert property ((rd_st && s_q.selftest_reply == 8'haa) |=> selftest_start_clr ##1 !selftest_start_clr)
        else $error("self-test start clear pulse wrong");
    supplier_fixed_a: assert property ((reg_rd && reg_addr == `ASR_OFF_SUPPLIER) |=> reg_rdata == `ASR_SUPPLIER_ID)
        else $error("supplier id changed");
    ori_hold_a: assert property (rd_busy |=> $stable(s_q.ori_now) && $stable(s_q.ori_prior))
        else $error("orientation moved during read");
    ori_onehot_a: assert property ($onehot(s_q.ori_now) || !$onehot(s_q.ori_pend_val))
        else $error("orientation not one-hot");
    tap_code_a: assert property (s_q.tap_kind != 2'h3)
        else $error("tap kind code 11 produced");
    release_clear_a: assert property ((rd_rel && !tap_ev && !motion_ev && !ns_ev && !ori_changed && !motion_unlatched)
        |=> (s_q.tap_dir == 6'h00) && !s_q.any_evt && !irq_out && !s_q.ori_chg)
        else $error("release left a source set");
    new_sample_clr_a: assert property ((rd_accel && !ns_ev) |=> !s_q.new_sample)
        else $error("new sample flag not cleared");
    main_write_a: assert property (wr_main |=> s_q.main_ctl == $past(reg_wdata))
        else $error("main control write lost");
    ro_write_a: assert property ((reg_wr && reg_addr == `ASR_OFF_ORI_NOW && !ori_take) |=> $stable(s_q.ori_now))
        else $error("write to read-only register took effect");

    // Reply moves only on its read or on a start
    st_steady_a: assert property ((!rd_st && !st_rise)
        |=> $stable(s_q.selftest_reply))
        else $error("self-test reply moved unasked");

    // Clear pulse only after reading an armed reply
    st_clr_quiet_a: assert property (!(rd_st && s_q.selftest_reply == `ASR_ST_ACTIVE)
        |=> !selftest_start_clr)
        else $error("spurious self-test clear");

    // Reply read returns the value before the restore
    st_read_a: assert property (rd_st
        |=> reg_rdata == $past(s_q.selftest_reply))
        else $error("self-test reply read wrong");

    // Current orientation read
    ori_now_read_a: assert property ((reg_rd && reg_addr == `ASR_OFF_ORI_NOW)
        |=> reg_rdata == {2'h0, $past(s_q.ori_now)})
        else $error("orientation now read wrong");

    // Prior orientation read
    ori_prior_read_a: assert property ((reg_rd && reg_addr == `ASR_OFF_ORI_PRIOR)
        |=> reg_rdata == {2'h0, $past(s_q.ori_prior)})
        else $error("orientation prior read wrong");

    // Applying a state shifts the old one into prior
    ori_shift_a: assert property (ori_take
        |=> s_q.ori_prior == $past(s_q.ori_now))
        else $error("prior orientation not shifted");

    // Applying a state takes the pending value
    ori_apply_a: assert property (ori_take
        |=> s_q.ori_now == $past(s_q.ori_pend_val))
        else $error("pending orientation not applied");

    // A read strobe freezes both orientation registers
    ori_read_freeze_a: assert property (reg_rd
        |=> $stable(s_q.ori_now) && $stable(s_q.ori_prior))
        else $error("orientation moved on a read");

    // Nothing pending means nothing moves
    ori_idle_a: assert property (!s_q.ori_pend
        |=> $stable(s_q.ori_now) && $stable(s_q.ori_prior))
        else $error("orientation moved with nothing pending");

    // Top two prior orientation bits read zero
    ori_top_zero_a: assert property ((reg_rd && reg_addr == `ASR_OFF_ORI_PRIOR)
        |=> reg_rdata[7:6] == 2'h0)
        else $error("orientation top bits set");

    // Tap direction read
    tap_read_a: assert property ((reg_rd && reg_addr == `ASR_OFF_TAP_DIR)
        |=> reg_rdata == {2'h0, $past(s_q.tap_dir)})
        else $error("tap direction read wrong");

    // Event source layout on read
    evt_read_a: assert property ((reg_rd && reg_addr == `ASR_OFF_EVT_SRC)
        |=> reg_rdata == {3'h0, $past(s_q.new_sample), $past(s_q.tap_kind), $past(s_q.motion), $past(s_q.ori_chg)})
        else $error("event source read wrong");

    // Status read carries the combined flag in bit 4
    status_read_a: assert property ((reg_rd && reg_addr == `ASR_OFF_STATUS)
        |=> reg_rdata == {3'h0, $past(s_q.any_evt), 4'h0})
        else $error("status read wrong");

    // Tap source holds until released or replaced
    tap_hold_a: assert property ((!tap_ev && !rd_rel)
        |=> $stable(s_q.tap_dir) && $stable(s_q.tap_kind))
        else $error("tap source lost its latch");

    // Tap kind code follows the event
    tap_kind_a: assert property (tap_ev
        |=> s_q.tap_kind == ($past(evt.tap_double) ? `ASR_TAP_DOUBLE : `ASR_TAP_SINGLE))
        else $error("tap kind code wrong");

    // Latched motion sets its flag
    motion_latch_a: assert property ((motion_ev && !motion_unlatched)
        |=> s_q.motion)
        else $error("motion event not latched");

    // Latched motion stays until release
    motion_keep_a: assert property ((!motion_unlatched && !rd_rel && s_q.motion)
        |=> s_q.motion)
        else $error("latched motion flag dropped");

    // Unlatched motion follows detection
    motion_follow_a: assert property (motion_unlatched
        |=> s_q.motion == $past(motion_ev))
        else $error("unlatched motion does not follow");

    // Orientation change sets its flag
    ori_chg_set_a: assert property (ori_changed
        |=> s_q.ori_chg)
        else $error("orientation change not flagged");

    // No change keeps the flag at zero
    ori_chg_quiet_a: assert property ((!ori_changed && !s_q.ori_chg)
        |=> !s_q.ori_chg)
        else $error("orientation flag set without change");

    // Enabled events set the combined flag
    any_set_a: assert property ((tap_ev || ori_changed || (motion_ev && !motion_unlatched))
        |=> s_q.any_evt)
        else $error("combined flag missed an event");

    // Enabled new sample reaches the interrupt
    ns_irq_a: assert property ((ns_ev && s_q.main_ctl[`ASR_MC_NSIRQ])
        |=> irq_out)
        else $error("new sample interrupt missing");

    // Disabled new sample stays off the interrupt
    ns_quiet_a: assert property ((!s_q.main_ctl[`ASR_MC_NSIRQ] && !tap_ev && !motion_ev && !ori_changed
        && !s_q.any_evt && !motion_unlatched) |=> !irq_out)
        else $error("interrupt raised by masked new sample");

    // Fresh data sets the new sample flag
    ns_set_a: assert property (ns_ev
        |=> s_q.new_sample)
        else $error("new sample flag not set");

    // Standby keeps tap direction, orientation change and combined flags still
    standby_quiet_a: assert property ((!mode_on && !rd_rel)
        |=> $stable(s_q.tap_dir) && $stable(s_q.ori_chg) && $stable(s_q.any_evt))
        else $error("event latched in standby");

    // Disabled tap detection latches nothing
    tap_gate_a: assert property ((!s_q.main_ctl[`ASR_MC_TAP_EN] && !rd_rel)
        |=> $stable(s_q.tap_kind))
        else $error("tap latched while disabled");

    // Main control changes only on its own write
    main_hold_a: assert property (!wr_main
        |=> $stable(s_q.main_ctl))
        else $error("main control changed unwritten");

    // Writes never touch the self-test reply
    ro_write_st_a: assert property ((reg_wr && !rd_st && !st_rise)
        |=> $stable(s_q.selftest_reply))
        else $error("write reached the self-test reply");

endmodule

/* bench/asr_host_model.sv */
// Host side model: reads and writes the register bank one byte at a time.
// Assumes strobes launch 1 ns after the rising clock edge.
`timescale 1ns/100ps

module asr_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    logic [7:0] ctl_q = 8'h00;

    // Idle lines at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // Released lines toggle so a stale value is never mistaken for data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // Read data is taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask

    // Settings only change in standby
    task automatic set_ctrl(input logic [7:0] v);
        if (ctl_q[7] && (v[6:0] != ctl_q[6:0]))
            wr(8'h1b, {1'b0, ctl_q[6:0]});
        wr(8'h1b, v);
        ctl_q = v;
    endtask
endmodule

/* bench/asr_regs_tb_top.sv */
// Self-checking bench for the register bank against an array model.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
`include "asr_consts.svh"

module asr_regs_tb_top;
    import asr_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic rd_busy = 1'b0;
    logic [11:0] z_accel = 12'h000;
    asr_evt_t evt = '0;
    asr_evt_t e;
    logic motion_unlatched = 1'b0;
    logic selftest_start = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, v;
    logic reg_wr, reg_rd, selftest_start_clr, irq_out;
    asr_ctrl_t ctrl;
    int n_fail = 0;
    int tests_run = 0;
    int m[0:31];
    logic [31:0] seed = 32'd48;
    logic [7:0] al[7] = '{8'h0b, 8'h0c, 8'h0f, 8'h10, 8'h11, 8'h1b, 8'h1f};

    always #5 ref_clk = ~ref_clk;

    asr_regs uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .rd_busy(rd_busy), .z_accel(z_accel), .evt(evt),
        .motion_unlatched(motion_unlatched), .selftest_start(selftest_start), .reg_rdata(reg_rdata),
        .selftest_start_clr(selftest_start_clr), .ctrl(ctrl), .irq_out(irq_out));
    asr_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read side effects kept in the model: release, data read, reply restore
    task automatic rd_chk(input logic [7:0] a);
        host.rd(a, rv);
        if (a != `ASR_OFF_RELEASE)
            check(rv, m[a]);
        else begin
            m[21] = 0;
            m[22] = 0;
            m[24] = 0;
        end
        if (a == `ASR_OFF_Z_HIGH)
            m[22] &= ~16;
        if (a == `ASR_OFF_SELFTEST_REPLY)
            m[12] = 8'h55;
    endtask

    task automatic pulse();
        @(posedge ref_clk) #1;
        evt = e;
        @(posedge ref_clk) #1;
        evt = '0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        for (int i = 0; i < 32; i++) m[i] = 0;
        m[12] = 8'h55;
        m[15] = `ASR_SUPPLIER_ID;
        m[16] = 8'h20;
        m[17] = 8'h20;
        repeat (4) @(posedge ref_clk);
        #1 resetn = 1'b1;
        foreach (al[i]) rd_chk(al[i]);
        // Writes to read-only places must change nothing
        foreach (al[i]) if (al[i] != 8'h1b) host.wr(al[i], rnd());
        foreach (al[i]) rd_chk(al[i]);
        $display("test done: reset and read-only");
        for (int k = 0; k < 3; k++) begin
            v = (rnd() & 8'h63) | 8'(k << 3);
            host.set_ctrl(v);
            m[27] = v;
            rd_chk(8'h1b);
            check(ctrl, v);
        end
        z_accel = 12'({rnd(), rnd()});
        m[11] = z_accel[11:4];
        rd_chk(8'h0b);
        selftest_start = 1'b1;
        repeat (2) @(posedge ref_clk);
        m[12] = 8'haa;
        rd_chk(8'h0c);
        check({7'h0, selftest_start_clr}, 8'h01);
        selftest_start = 1'b0;
        rd_chk(8'h0c);
        $display("test done: control, data, self-test");
        host.set_ctrl(8'h87);
        m[27] = 8'h87;
        for (int t = 0; t < 2; t++) begin
            e = '0;
            e.tap_event = 1'b1;
            e.tap_double = t;
            e.tap_dir = t ? 6'h01 : 6'h20;
            pulse();
            m[21] = e.tap_dir;
            m[22] = (t + 1) << 2;
            m[24] = 8'h10;
            check({7'h0, irq_out}, 8'h01);
            foreach (m[i]) if (i >= 21 && i <= 24 && i != 23) rd_chk(i);
            rd_chk(8'h1a);
            check({7'h0, irq_out}, 8'h00);
            foreach (m[i]) if (i >= 21 && i <= 24 && i != 23) rd_chk(i);
        end
        // New sample without its interrupt enable stays off the pin
        e = '0;
        e.new_sample = 1'b1;
        pulse();
        m[22] = 8'h10;
        rd_chk(8'h16);
        rd_chk(8'h18);
        check({7'h0, irq_out}, 8'h00);
        rd_chk(8'h0b);
        rd_chk(8'h16);
        $display("test done: events and release");
        rd_busy = 1'b1;
        e = '0;
        e.ori_update = 1'b1;
        e.ori_state = 6'h01;
        pulse();
        rd_chk(8'h10);
        rd_busy = 1'b0;
        repeat (2) @(posedge ref_clk);
        m[16] = 8'h01;
        m[22] = 8'h01;
        m[24] = 8'h10;
        foreach (al[i]) rd_chk(al[i]);
        rd_chk(8'h16);
        rd_chk(8'h1a);
        motion_unlatched = 1'b1;
        evt.motion_level = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check({7'h0, irq_out}, 8'h01);
        m[22] = 8'h02;
        rd_chk(8'h16);
        evt.motion_level = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check({7'h0, irq_out}, 8'h00);
        m[22] = 8'h00;
        rd_chk(8'h16);
        rd_chk(8'h18);
        // New sample with its interrupt enable reaches the pin
        host.set_ctrl(8'ha7);
        m[27] = 8'ha7;
        rd_chk(8'h1b);
        e = '0;
        e.new_sample = 1'b1;
        pulse();
        m[22] = 8'h10;
        m[24] = 8'h10;
        check({7'h0, irq_out}, 8'h01);
        rd_chk(8'h18);
        rd_chk(8'h1a);
        check({7'h0, irq_out}, 8'h00);
        rd_chk(8'h16);
        $display("test done: orientation and motion");
        report_and_stop();
    end
endmodule
